// >>> logic/sbc_pkg.sv
package sbc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] SBC_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] SBC_MASK_OFS = 32'h0000_0004;
  localparam logic [31:0] SBC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SBC_MASK_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // bank_address_control fields
  // ----------------------------------------------------------------
  localparam int SBC_BASE_HI = 31;
  localparam int SBC_BASE_LO = 18;
  localparam int SBC_RFSH_BIT = 15;
  localparam int SBC_LAT_HI = 13;
  localparam int SBC_LAT_LO = 12;
  localparam int SBC_CBM_HI = 10;
  localparam int SBC_CBM_LO = 8;
  localparam int SBC_MRS_BIT = 6;
  localparam int SBC_PW_HI = 5;
  localparam int SBC_PW_LO = 4;
  localparam int SBC_PALL_BIT = 3;
  localparam int SBC_PAGE_BIT = 2;

  // ----------------------------------------------------------------
  // bank_address_mask fields
  // ----------------------------------------------------------------
  localparam int SBC_WP_BIT = 8;
  localparam int SBC_CPU_BIT = 6;
  localparam int SBC_AM_BIT = 5;
  localparam int SBC_SC_BIT = 4;
  localparam int SBC_SD_BIT = 3;
  localparam int SBC_UC_BIT = 2;
  localparam int SBC_UD_BIT = 1;
  localparam int SBC_V_BIT = 0;

  // ----------------------------------------------------------------
  // Encodings and pin layout
  // ----------------------------------------------------------------
  localparam logic [1:0] SBC_LAT_ONE = 2'h1;
  localparam logic [1:0] SBC_PW_32 = 2'h0;
  localparam logic [1:0] SBC_PW_8 = 2'h1;
  localparam logic [1:0] SBC_PW_16 = 2'h2;
  localparam logic [5:0] SBC_W32 = 6'h20;
  localparam logic [5:0] SBC_W16 = 6'h10;
  localparam logic [5:0] SBC_W8 = 6'h08;
  localparam logic [4:0] SBC_CBM_PIN_BASE = 5'h10;
  localparam int SBC_ROW_HI = 24;
  localparam int SBC_ROW_LO = 9;
  localparam logic [2:0] SBC_OP_NOP = 3'h7;
  localparam logic [2:0] SBC_OP_ACT = 3'h3;
  localparam logic [2:0] SBC_OP_RD = 3'h5;
  localparam logic [2:0] SBC_OP_WR = 3'h4;
  localparam logic [2:0] SBC_OP_PRE = 3'h2;
  localparam logic [2:0] SBC_OP_REF = 3'h1;
  localparam logic [2:0] SBC_OP_MRS = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SBC_CLK_PERIOD_NS = 10;
  localparam int SBC_RFSH_PERIOD_NS = 15625;
  localparam int SBC_RFSH_CYCLES = SBC_RFSH_PERIOD_NS / SBC_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SBC_ST_IDLE = 3'b001,
    SBC_ST_COL = 3'b010,
    SBC_ST_WAIT = 3'b100
  } sbc_state_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [23:0] a;
  } sbc_sdram_cmd_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic write;
    logic cpu_space;
    logic alt_master;
    logic supervisor;
    logic code;
  } sbc_acc_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic rd_sample;
  } sbc_acc_rsp_t;

endpackage

// >>> logic/sbc_bank_ctrl.sv
// Overview of operation
// - Compare address bits 31..18 with the bank base field to detect a hit.
// - No periodic auto-refresh while the refresh enable bit is clear.
// - Latency field 01 samples read data in the same cycle as the column strobe.
// - Map field 010 puts command bit on pin 19, bank bits above.
// - Page mode set keeps the open row active across same-page accesses.
// - With mode-load trigger set, next bank access becomes a mode set command.
// - Precharge trigger plus any bank access issues a precharge-all command.
// - Mode set drives the host address unchanged so SDRAM A9..A0 carry the value.
// - Address bits with a set mask bit are left out of the compare.
// - Write-protect clear allows reads and writes; set refuses writes.
// - CPU-space filter set keeps CPU-space cycles off the bank.
// - Alternate-master filter set keeps alternate master accesses off the bank.
// - Each access class is blocked when its filter bit is set.
// - Mode set address is not multiplexed; reads or writes both trigger it.
// - Only latencies of one or two cycles are supported.
//
// Added by the designer: the register offsets and register access over AHB-Lite.
module sbc_bank_ctrl #(
  parameter int RFSH_CYCLES = sbc_pkg::SBC_RFSH_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Bank access request and answer
  input wire sbc_pkg::sbc_acc_req_t acc_req,
  output sbc_pkg::sbc_acc_rsp_t acc_rsp,
  // SDRAM command pins
  output sbc_pkg::sbc_sdram_cmd_t sdram_cmd,
  // Bank data width
  output logic [5:0] bank_width
);
  import sbc_pkg::*;

  localparam int RW = $clog2(RFSH_CYCLES + 1);
  localparam logic [RW-1:0] RFSH_LOAD = RW'(RFSH_CYCLES - 1);
  localparam int RWD = SBC_ROW_HI - SBC_ROW_LO + 1;

  typedef struct packed {
    sbc_state_t st;
    logic [31:0] ctrl;
    logic [31:0] mask;
    logic ph_wr;
    logic ph_ctrl;
    logic ph_mask;
    logic [31:0] rdata;
    logic [RW-1:0] rfsh_cnt;
    logic rfsh_due;
    logic row_open;
    logic [RWD-1:0] open_row;
    sbc_sdram_cmd_t cmd;
    sbc_acc_rsp_t rsp;
    logic [5:0] width;
    logic ready;
  } sbc_regs_t;

  sbc_regs_t r_r;
  sbc_regs_t r_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic bank_hit(input logic [31:0] ctrl, input logic [31:0] mask,
                                    input sbc_acc_req_t q);
    logic [13:0] diff;
    logic blocked;
    diff = (q.addr[SBC_BASE_HI:SBC_BASE_LO] ^ ctrl[SBC_BASE_HI:SBC_BASE_LO])
         & ~mask[SBC_BASE_HI:SBC_BASE_LO];
    blocked = (mask[SBC_CPU_BIT] & q.cpu_space)
            | (mask[SBC_AM_BIT] & q.alt_master)
            | (mask[SBC_SC_BIT] & q.supervisor & q.code)
            | (mask[SBC_SD_BIT] & q.supervisor & ~q.code)
            | (mask[SBC_UC_BIT] & ~q.supervisor & q.code)
            | (mask[SBC_UD_BIT] & ~q.supervisor & ~q.code);
    return mask[SBC_V_BIT] & (diff == 14'h0000) & ~blocked;
  endfunction

  // Command bit lands on pin 17 + map field; pins index from A1
  function automatic logic [23:0] put_cmd_bit(input logic [23:0] pins,
                                              input logic [2:0] cmd_bit_map, input logic val);
    logic [23:0] p;
    logic [4:0] idx;
    p = pins;
    idx = SBC_CBM_PIN_BASE + {2'h0, cmd_bit_map};
    p[idx] = val;
    return p;
  endfunction

  function automatic sbc_sdram_cmd_t mk_cmd(input logic [2:0] op, input logic [23:0] a);
    sbc_sdram_cmd_t c;
    c.cs_n = (op == SBC_OP_NOP);
    c.ras_n = op[2];
    c.cas_n = op[1];
    c.we_n = op[0];
    c.a = a;
    return c;
  endfunction

  function automatic logic [5:0] width_of(input logic [1:0] pw);
    unique case (pw)
      SBC_PW_32: width_of = SBC_W32;
      SBC_PW_8: width_of = SBC_W8;
      default: width_of = SBC_W16;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic hit;
  logic take;
  logic same_row;
  logic [23:0] raw_pins;
  logic [23:0] col_pins;
  logic addr_ok;

  always_comb begin
    r_nxt = r_r;
    hit = bank_hit(r_r.ctrl, r_r.mask, acc_req);
    // Requester holds req until it sees done; skip the cycle done stands
    take = acc_req.req & ~r_r.rsp.done;
    same_row = r_r.row_open & (r_r.open_row == acc_req.addr[SBC_ROW_HI:SBC_ROW_LO]);
    raw_pins = acc_req.addr[24:1];
    col_pins = raw_pins;
    col_pins[15:8] = acc_req.addr[8:1];
    col_pins = put_cmd_bit(col_pins, r_r.ctrl[SBC_CBM_HI:SBC_CBM_LO],
                           ~r_r.ctrl[SBC_PAGE_BIT]);
    r_nxt.cmd = mk_cmd(SBC_OP_NOP, r_r.cmd.a);
    r_nxt.rsp = '0;
    r_nxt.ready = 1'b1;

    // Refresh timer runs only while enabled
    if (!r_r.ctrl[SBC_RFSH_BIT]) begin
      r_nxt.rfsh_cnt = RFSH_LOAD;
      r_nxt.rfsh_due = 1'b0;
    end else if (r_r.rfsh_cnt == '0) begin
      r_nxt.rfsh_cnt = RFSH_LOAD;
    end else begin
      r_nxt.rfsh_cnt = r_r.rfsh_cnt - 1'b1;
    end

    unique case (r_r.st)
      SBC_ST_IDLE: begin
        // Refresh enable gates a pending refresh too, so clearing it stops commands
        if (r_r.rfsh_due && r_r.row_open && r_r.ctrl[SBC_RFSH_BIT]) begin
          r_nxt.cmd = mk_cmd(SBC_OP_PRE, put_cmd_bit(r_r.cmd.a,
                             r_r.ctrl[SBC_CBM_HI:SBC_CBM_LO], 1'b1));
          r_nxt.row_open = 1'b0;
        end else if (r_r.rfsh_due && r_r.ctrl[SBC_RFSH_BIT]) begin
          r_nxt.cmd = mk_cmd(SBC_OP_REF, r_r.cmd.a);
          r_nxt.rfsh_due = 1'b0;
        end else if (take && (!hit || (acc_req.write && r_r.mask[SBC_WP_BIT]))) begin
          r_nxt.rsp.done = 1'b1;
          r_nxt.rsp.err = 1'b1;
        end else if (take && r_r.ctrl[SBC_PALL_BIT]) begin
          r_nxt.cmd = mk_cmd(SBC_OP_PRE, put_cmd_bit(raw_pins,
                             r_r.ctrl[SBC_CBM_HI:SBC_CBM_LO], 1'b1));
          r_nxt.row_open = 1'b0;
          r_nxt.ctrl[SBC_PALL_BIT] = 1'b0;
          r_nxt.rsp.done = 1'b1;
        end else if (take && r_r.ctrl[SBC_MRS_BIT] && r_r.row_open) begin
          // Mode set needs all banks idle
          r_nxt.cmd = mk_cmd(SBC_OP_PRE, put_cmd_bit(raw_pins,
                             r_r.ctrl[SBC_CBM_HI:SBC_CBM_LO], 1'b1));
          r_nxt.row_open = 1'b0;
        end else if (take && r_r.ctrl[SBC_MRS_BIT]) begin
          r_nxt.cmd = mk_cmd(SBC_OP_MRS, raw_pins);
          r_nxt.ctrl[SBC_MRS_BIT] = 1'b0;
          r_nxt.rsp.done = 1'b1;
        end else if (take && same_row && r_r.ctrl[SBC_PAGE_BIT]) begin
          r_nxt.st = SBC_ST_COL;
        end else if (take && r_r.row_open) begin
          r_nxt.cmd = mk_cmd(SBC_OP_PRE, put_cmd_bit(raw_pins,
                             r_r.ctrl[SBC_CBM_HI:SBC_CBM_LO], 1'b1));
          r_nxt.row_open = 1'b0;
        end else if (take) begin
          r_nxt.cmd = mk_cmd(SBC_OP_ACT, raw_pins);
          r_nxt.st = SBC_ST_COL;
        end
      end
      SBC_ST_COL: begin
        // Auto-precharge rides on the command bit when page mode is off
        r_nxt.cmd = mk_cmd(acc_req.write ? SBC_OP_WR : SBC_OP_RD, col_pins);
        r_nxt.row_open = r_r.ctrl[SBC_PAGE_BIT];
        r_nxt.open_row = acc_req.addr[SBC_ROW_HI:SBC_ROW_LO];
        if (acc_req.write || r_r.ctrl[SBC_LAT_HI:SBC_LAT_LO] == SBC_LAT_ONE) begin
          r_nxt.rsp.done = 1'b1;
          r_nxt.rsp.rd_sample = ~acc_req.write;
          r_nxt.st = SBC_ST_IDLE;
        end else begin
          r_nxt.st = SBC_ST_WAIT;
        end
      end
      SBC_ST_WAIT: begin
        r_nxt.rsp.done = 1'b1;
        r_nxt.rsp.rd_sample = 1'b1;
        r_nxt.st = SBC_ST_IDLE;
      end
      default: r_nxt.st = SBC_ST_IDLE;
    endcase

    // Timer expiry sets the flag after any clear above, so it is never lost
    if (r_r.ctrl[SBC_RFSH_BIT] && r_r.rfsh_cnt == '0) begin
      r_nxt.rfsh_due = 1'b1;
    end

    // ----------------------------------------------------------------
    // AHB-Lite data phase, then address phase
    // ----------------------------------------------------------------
    // Software write lands after the self-clearing triggers, so it wins
    if (r_r.ph_wr && r_r.ph_ctrl) begin
      r_nxt.ctrl = hwdata;
    end
    if (r_r.ph_wr && r_r.ph_mask) begin
      r_nxt.mask = hwdata;
    end
    addr_ok = hsel & htrans[1] & hready;
    r_nxt.ph_wr = addr_ok & hwrite;
    r_nxt.ph_ctrl = addr_ok & (haddr == SBC_CTRL_OFS);
    r_nxt.ph_mask = addr_ok & (haddr == SBC_MASK_OFS);
    if (addr_ok && !hwrite) begin
      // Unmapped reads answer zero
      r_nxt.rdata = (haddr == SBC_CTRL_OFS) ? r_nxt.ctrl :
                    (haddr == SBC_MASK_OFS) ? r_nxt.mask : 32'h0000_0000;
    end
    r_nxt.width = width_of(r_nxt.ctrl[SBC_PW_HI:SBC_PW_LO]);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_r.st <= SBC_ST_IDLE;
      r_r.ctrl <= SBC_CTRL_RST;
      r_r.mask <= SBC_MASK_RST;
      r_r.ph_wr <= 1'b0;
      r_r.ph_ctrl <= 1'b0;
      r_r.ph_mask <= 1'b0;
      r_r.rdata <= 32'h0000_0000;
      r_r.rfsh_cnt <= RFSH_LOAD;
      r_r.rfsh_due <= 1'b0;
      r_r.row_open <= 1'b0;
      r_r.open_row <= '0;
      r_r.cmd <= {4'hF, 24'h00_0000};
      r_r.rsp <= '0;
      r_r.width <= SBC_W32;
      r_r.ready <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign hreadyout = r_r.ready;
  assign hresp = 1'b0;
  assign hrdata = r_r.rdata;
  assign acc_rsp = r_r.rsp;
  assign sdram_cmd = r_r.cmd;
  assign bank_width = r_r.width;

endmodule

// >>> verif/sbc_bank_ctrl_monitor.sv
module sbc_bank_ctrl_chk #(
  parameter int RFSH_CYCLES = sbc_pkg::SBC_RFSH_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Bank side
  input wire sbc_pkg::sbc_acc_req_t acc_req,
  input wire sbc_pkg::sbc_acc_rsp_t acc_rsp,
  input wire sbc_pkg::sbc_sdram_cmd_t sdram_cmd,
  input wire logic [5:0] bank_width
);
  import sbc_pkg::*;
  // ----------
  // Register shadows
  // ----------
  // Triggers tracked apart, since the design clears them itself
  logic [31:0] ctl_r, msk_r, wa_r;
  logic wp_r, pa_r, mr_r, ok, hit, blk;
  logic [2:0] op;
  assign op = sdram_cmd.cs_n ? SBC_OP_NOP : {sdram_cmd.ras_n, sdram_cmd.cas_n, sdram_cmd.we_n};
  assign hit = msk_r[0] && (((acc_req.addr[31:18] ^ ctl_r[31:18]) & ~msk_r[31:18]) == 14'h0);
  assign blk = acc_req.cpu_space && msk_r[6] || acc_req.alt_master && msk_r[5]
    || msk_r[{acc_req.supervisor, acc_req.code} + 3'h1];
  assign ok = acc_rsp.done && !acc_rsp.err;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_r <= '0;
      msk_r <= '0;
      wa_r <= '0;
      wp_r <= 1'b0;
      pa_r <= 1'b0;
      mr_r <= 1'b0;
    end else begin
      wp_r <= hsel && htrans[1] && hready && hwrite;
      wa_r <= haddr;
      if (ok) begin
        pa_r <= 1'b0;
        mr_r <= 1'b0;
      end
      if (wp_r && wa_r == SBC_CTRL_OFS) begin
        ctl_r <= hwdata;
        pa_r <= hwdata[3];
        mr_r <= hwdata[6];
      end
      if (wp_r && wa_r == SBC_MASK_OFS) begin
        msk_r <= hwdata;
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_no_refresh: assert property (!ctl_r[15] |-> op != SBC_OP_REF)
    else $error("refresh while disabled");
  chk_rd_latency: assert property (op == SBC_OP_RD && ctl_r[13:12] == 2'h1
    |-> acc_rsp.rd_sample) else $error("read sample not with column strobe");
  chk_rd_slow: assert property (op == SBC_OP_RD && ctl_r[13:12] != 2'h1
    |-> !acc_rsp.rd_sample ##1 acc_rsp.rd_sample) else $error("late read sample wrong");
  chk_addr_miss: assert property (acc_rsp.done && !hit |-> acc_rsp.err)
    else $error("miss not refused");
  chk_class_block: assert property (acc_rsp.done && blk |-> acc_rsp.err)
    else $error("filtered access let through");
  chk_wr_protect: assert property (acc_rsp.done && acc_req.write && msk_r[8]
    |-> acc_rsp.err) else $error("protected write let through");
  chk_access_ok: assert property (acc_rsp.done && hit && !blk && !(acc_req.write && msk_r[8])
    |-> !acc_rsp.err) else $error("good access refused");
  chk_pall_cmd: assert property (ok && pa_r && ctl_r[10:8] == 3'h2
    |-> op == SBC_OP_PRE && sdram_cmd.a[18]) else $error("no precharge-all");
  chk_mode_cmd: assert property (ok && mr_r && !pa_r
    |-> op == SBC_OP_MRS && sdram_cmd.a == acc_req.addr[24:1]) else $error("bad mode set");
  chk_port_width: assert property (ctl_r[5:4] == 2'h2 && $past(ctl_r[5:4]) == 2'h2
    |-> bank_width == SBC_W16) else $error("port width not 16");
endmodule

// >>> verif/sbc_sdram_model.sv
module sbc_sdram_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Command pins
  input wire sbc_pkg::sbc_sdram_cmd_t cmd,
  // Activity counts
  output int n_act,
  output int n_ref
);
  timeunit 1ns;
  timeprecision 1ps;
  import sbc_pkg::*;
  // ----------
  // Command counting
  // ----------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_act <= 0;
      n_ref <= 0;
    end else if (!cmd.cs_n && {cmd.ras_n, cmd.cas_n, cmd.we_n} == SBC_OP_ACT) begin
      n_act <= n_act + 1;
    end else if (!cmd.cs_n && {cmd.ras_n, cmd.cas_n, cmd.we_n} == SBC_OP_REF) begin
      n_ref <= n_ref + 1;
    end
  end
endmodule

// >>> verif/tb_sdram_bank_config_init.sv
module tb_sdram_bank_config_init;
  timeunit 1ns;
  timeprecision 1ps;
  import sbc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_ph = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] v;
  logic [31:0] r;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [5:0] bank_width;
  sbc_acc_req_t acc_req = '0;
  sbc_acc_rsp_t acc_rsp;
  sbc_sdram_cmd_t sdram_cmd;
  logic [31:0] exp_q[$];
  logic [3:0] fl[6] = '{4'h8, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  logic [1:0] er[6] = '{2'h2, 2'h2, 2'h2, 2'h0, 2'h2, 2'h0};
  int n_act;
  int n_ref;
  int a0;
  int n_mismatch = 0;
  int checks = 0;
  always #5 hclk = ~hclk;
  // Short refresh period keeps the run brief
  sbc_bank_ctrl #(.RFSH_CYCLES(20)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .acc_req(acc_req),
    .acc_rsp(acc_rsp), .sdram_cmd(sdram_cmd), .bank_width(bank_width));
  sbc_sdram_model mdl_u (.hclk(hclk), .hresetn(hresetn), .cmd(sdram_cmd), .n_act(n_act),
    .n_ref(n_ref));
  // ----------
  // Checking and bus tasks
  // ----------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask
  task automatic acc(input logic [31:0] a, input logic w, input logic [3:0] f,
                     input logic [1:0] e);
    exp_q.push_back({30'h0, e});
    acc_req <= {1'b1, a, w, f};
    do @(posedge hclk); while (acc_rsp.done !== 1'b1);
    acc_req.req <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    if (acc_rsp.done === 1'b1 || rd_ph) begin
      r = exp_q.size() == 0 ? 32'hdead_beef : exp_q.pop_front();
      cmp(rd_ph ? hrdata : {30'h0, acc_rsp.err, acc_rsp.rd_sample}, r);
    end
    rd_ph <= hsel && htrans[1] && !hwrite;
  end
  initial begin
    repeat (3000) @(posedge hclk);
    n_mismatch++;
    results();
  end
  initial begin
    v = $urandom(32'h17d6_ef8a);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(SBC_CTRL_OFS, SBC_CTRL_RST);
    rd(SBC_MASK_OFS, SBC_MASK_RST);
    rd(32'h0000_0008, 32'h0);
    acc(32'hff88_0000, 1'b1, 4'h0, 2'h2);
    v = $urandom & 32'hffff_017f;
    ahb(1'b1, SBC_MASK_OFS, v);
    rd(SBC_MASK_OFS, v);
    v = $urandom & 32'hfffc_3734;
    ahb(1'b1, SBC_CTRL_OFS, v);
    rd(SBC_CTRL_OFS, v);
    ahb(1'b1, SBC_CTRL_OFS, 32'hff88_1220);
    ahb(1'b1, SBC_MASK_OFS, 32'h0074_0075);
    foreach (fl[i]) acc(32'hffe8_0000, 1'b1, fl[i], er[i]);
    cmp({26'h0, bank_width}, {26'h0, SBC_W16});
    cmp({31'h0, hresp}, 32'h0000_0000);
    acc(32'hff80_0000, 1'b1, 4'h0, 2'h2);
    ahb(1'b1, SBC_CTRL_OFS, 32'hff88_1228);
    acc(32'hff88_0000, 1'b1, 4'h0, 2'h0);
    ahb(1'b1, SBC_CTRL_OFS, 32'hff88_1224);
    a0 = n_act;
    acc(32'hff88_0010, 1'b0, 4'h0, 2'h1);
    acc(32'hff88_0014, 1'b0, 4'h2, 2'h1);
    cmp(32'(n_act - a0), 32'h1);
    ahb(1'b1, SBC_CTRL_OFS, 32'hff88_2220);
    acc(32'hff88_0200, 1'b0, 4'h0, 2'h1);
    ahb(1'b1, SBC_MASK_OFS, 32'h0074_0175);
    acc(32'hff88_0000, 1'b1, 4'h0, 2'h2);
    acc(32'hff88_0000, 1'b0, 4'h2, 2'h1);
    ahb(1'b1, SBC_MASK_OFS, 32'h0074_0075);
    cmp(32'(n_ref), 32'h0);
    ahb(1'b1, SBC_CTRL_OFS, 32'hff88_9220);
    repeat (60) @(posedge hclk);
    cmp(32'(n_ref > 1), 32'h1);
    ahb(1'b1, SBC_MASK_OFS, 32'h007c_0075);
    ahb(1'b1, SBC_CTRL_OFS, 32'hff88_9260);
    acc(32'hff80_1000, 1'b1, 4'h0, 2'h0);
    ahb(1'b1, SBC_MASK_OFS, 32'h0074_0075);
    acc(32'hff88_0020, 1'b0, 4'h2, 2'h1);
    results();
  end
endmodule
bind sbc_bank_ctrl sbc_bank_ctrl_chk #(.RFSH_CYCLES(RFSH_CYCLES)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .acc_req(acc_req),
  .acc_rsp(acc_rsp), .sdram_cmd(sdram_cmd), .bank_width(bank_width));
